// >>> design/cpu_alu_branch_exec.sv
// Contract
// RL1: Add register to register, optionally with carry; flags Z C N V H; one cycle.
// RL2: Word add/subtract immediate on a register pair; flags Z C N V S; two cycles.
// RL3: Subtract register or constant, optionally with carry; flags Z C N V H; one cycle.
// RL4: AND, OR, XOR with register or constant; flags Z N V only; one cycle.
// RL5: Set-bits ORs mask; clear-bits ANDs with 0xFF minus mask; flags Z N V.
// RL6: Zero-or-minus test ANDs register with itself; flags Z N V.
// RL7: Integer multiplies write 16-bit product to R1:R0; flags Z C; two cycles.
// RL8: Fractional multiplies shift product left one first; flags Z C; two cycles.
// RL9: Indirect jump loads PC from Z; no flags; two cycles.
// RL10: Indirect call loads PC from Z, three cycles; relative call three cycles.
// RL11: Compare-skip-equal skips two or three on match, else plus one; no flags.
// RL12: Compare variants compute difference without storing; flags Z N V C H; one cycle.
// RL13: Skip on working register bit clear or set advances PC two or three.
// RL14: Skip on I/O register bit clear or set advances PC two or three.
// RL15: Branch on status bit set or clear goes to PC plus offset plus one.
// RL16: Signed branches test N xor V: zero for ge, one for lt.
// RL17: Unsigned branches test carry: zero for same-or-higher, one for lower.
// RL18: Carry branches taken on carry zero or one; no flag change.
// RL19: Half-carry branches taken on H one or zero.
// RL20: Overflow branch taken on V one, moving PC by offset plus one.
// RL21: Transfer-bit branches taken on T one or zero.
// RL22: Branch one cycle untaken, two taken; skip two or three by skipped length.
// RL23: Unlisted flags keep values; no-flag instructions leave status untouched.
`include "cpu_alu_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module cpu_alu_branch_exec #(
	parameter int PC_W = 16
) (
	input wire logic sys_clk_in,
	input wire logic rstn_in,
	input wire logic req_valid_in,
	input wire cpu_alu_pkg::exec_req_t req_in,
	output logic ready_out,
	output logic done_out,
	output cpu_alu_pkg::reg_write_t wr_out,
	output cpu_alu_pkg::ret_push_t push_out,
	output logic [7:0] status_out,
	output logic [PC_W-1:0] pc_out
);
	import cpu_alu_pkg::*;

	exec_state_t state_ff, nxt_state;
	logic [1:0] cnt_ff, nxt_cnt;
	logic ready_ff, nxt_ready;
	logic done_ff, nxt_done;
	logic [7:0] status_register_ff, nxt_status_register, pend_status_register_ff, nxt_pend_status_register;
	logic [PC_W-1:0] pc_ff, nxt_pc, pend_pc_ff, nxt_pend_pc;
	reg_write_t wr_ff, nxt_wr, pend_wr_ff, nxt_pend_wr;
	ret_push_t push_ff, nxt_push, pend_push_ff, nxt_pend_push;

	logic commit, take;
	logic [7:0] cur_status_register;
	logic [PC_W-1:0] cur_pc;
	logic [7:0] res, d, r;
	logic [8:0] wide;
	logic [4:0] nib;
	logic [15:0] wres, prod;
	logic [16:0] wwide;
	logic [7:0] fl;
	logic [1:0] cyc;
	logic [PC_W-1:0] npc;
	logic wr_en, wr_pair, wr_mul, cond, is_br, is_skip, cin;
	logic signed [17:0] sprod;
	logic signed [8:0] sa, sb;

	assign commit = (state_ff == ST_EXEC) && (cnt_ff == 2'd0);
	assign take = req_valid_in && ready_ff;
	assign cur_status_register = commit ? pend_status_register_ff : status_register_ff;
	assign cur_pc = commit ? pend_pc_ff : pc_ff;

	always_comb begin
		d = req_in.rd_val;
		r = req_in.rr_val;
		fl = cur_status_register; // RL23
		res = 8'h00;
		wres = 16'h0000;
		wide = 9'h000;
		nib = 5'h00;
		wwide = 17'h00000;
		sa = 9'sh000;
		sb = 9'sh000;
		sprod = 18'sh00000;
		prod = 16'h0000;
		wr_en = 1'b0;
		wr_pair = 1'b0;
		wr_mul = 1'b0;
		cyc = `CYC_ALU;
		cond = 1'b0;
		is_br = 1'b0;
		is_skip = 1'b0;
		cin = 1'b0;
		npc = cur_pc + PC_W'(`PC_STEP);
		case (req_in.op)
			OP_ADD, OP_ADD_CARRY: begin
				cin = (req_in.op == OP_ADD_CARRY) & cur_status_register[`SR_C];
				wide = {1'b0, d} + {1'b0, r} + {8'h00, cin}; // RL1
				nib = {1'b0, d[3:0]} + {1'b0, r[3:0]} + {4'h0, cin};
				res = wide[7:0];
				wr_en = 1'b1;
				fl[`SR_C] = wide[8];
				fl[`SR_H] = nib[4];
				fl[`SR_V] = (d[7] & r[7] & ~res[7]) | (~d[7] & ~r[7] & res[7]);
				fl[`SR_N] = res[7];
				fl[`SR_Z] = (res == 8'h00);
			end
			OP_SUB, OP_SUB_BORROW, OP_SUBTRACT_CONSTANT, OP_SUBTRACT_CONSTANT_WITH_BORROW,
			OP_COMPARE, OP_COMPARE_WITH_CARRY, OP_COMPARE_IMMEDIATE: begin
				cin = ((req_in.op == OP_SUB_BORROW) || (req_in.op == OP_SUBTRACT_CONSTANT_WITH_BORROW) ||
					(req_in.op == OP_COMPARE_WITH_CARRY)) & cur_status_register[`SR_C];
				wide = {1'b0, d} - {1'b0, r} - {8'h00, cin}; // RL3
				nib = {1'b0, d[3:0]} - {1'b0, r[3:0]} - {4'h0, cin};
				res = wide[7:0];
				wr_en = !((req_in.op == OP_COMPARE) || (req_in.op == OP_COMPARE_WITH_CARRY) ||
					(req_in.op == OP_COMPARE_IMMEDIATE)); // RL12
				fl[`SR_C] = wide[8];
				fl[`SR_H] = nib[4];
				fl[`SR_V] = (d[7] & ~r[7] & ~res[7]) | (~d[7] & r[7] & res[7]);
				fl[`SR_N] = res[7];
				if ((req_in.op == OP_SUB_BORROW) || (req_in.op == OP_SUBTRACT_CONSTANT_WITH_BORROW) ||
					(req_in.op == OP_COMPARE_WITH_CARRY)) begin
					fl[`SR_Z] = (res == 8'h00) & cur_status_register[`SR_Z];
				end else begin
					fl[`SR_Z] = (res == 8'h00);
				end
			end
			OP_AND, OP_AND_CONSTANT, OP_OR, OP_OR_CONSTANT, OP_EXCLUSIVE_OR,
			OP_SET_BITS_MASK, OP_CLEAR_BITS_MASK, OP_ZERO_MINUS_TEST: begin
				case (req_in.op)
					OP_AND, OP_AND_CONSTANT: res = d & r; // RL4
					OP_OR, OP_OR_CONSTANT: res = d | r; // RL4
					OP_EXCLUSIVE_OR: res = d ^ r; // RL4
					OP_SET_BITS_MASK: res = d | r; // RL5
					OP_CLEAR_BITS_MASK: res = d & (`MASK_ALL - r); // RL5
					default: res = d & d; // RL6
				endcase
				wr_en = 1'b1;
				fl[`SR_V] = 1'b0;
				fl[`SR_N] = res[7];
				fl[`SR_Z] = (res == 8'h00);
			end
			OP_WORD_ADD_IMMEDIATE, OP_WORD_SUBTRACT_IMMEDIATE: begin
				if (req_in.op == OP_WORD_ADD_IMMEDIATE) begin
					wwide = {1'b0, req_in.rd_hi_val, d} + {9'h000, r}; // RL2
					fl[`SR_V] = ~req_in.rd_hi_val[7] & wwide[15];
				end else begin
					wwide = {1'b0, req_in.rd_hi_val, d} - {9'h000, r}; // RL2
					fl[`SR_V] = req_in.rd_hi_val[7] & ~wwide[15];
				end
				wres = wwide[15:0];
				wr_en = 1'b1;
				wr_pair = 1'b1;
				cyc = `CYC_WORD;
				fl[`SR_C] = wwide[16];
				fl[`SR_N] = wres[15];
				fl[`SR_S] = wres[15] ^ fl[`SR_V];
				fl[`SR_Z] = (wres == 16'h0000);
			end
			OP_MULTIPLY, OP_SIGNED_MULTIPLY, OP_SIGNED_UNSIGNED_MULTIPLY, OP_FRACTIONAL_MULTIPLY,
			OP_FRACTIONAL_SIGNED_MULTIPLY, OP_FRACTIONAL_MIXED_MULTIPLY: begin
				sa = ((req_in.op == OP_MULTIPLY) || (req_in.op == OP_FRACTIONAL_MULTIPLY)) ?
					$signed({1'b0, d}) : $signed({d[7], d});
				sb = ((req_in.op == OP_SIGNED_MULTIPLY) || (req_in.op == OP_FRACTIONAL_SIGNED_MULTIPLY)) ?
					$signed({r[7], r}) : $signed({1'b0, r});
				sprod = sa * sb; // RL7
				prod = sprod[15:0];
				fl[`SR_C] = prod[15];
				if ((req_in.op == OP_FRACTIONAL_MULTIPLY) || (req_in.op == OP_FRACTIONAL_SIGNED_MULTIPLY) ||
					(req_in.op == OP_FRACTIONAL_MIXED_MULTIPLY)) begin
					wres = {prod[14:0], 1'b0}; // RL8
				end else begin
					wres = prod;
				end
				fl[`SR_Z] = (wres == 16'h0000);
				wr_en = 1'b1;
				wr_mul = 1'b1;
				cyc = `CYC_MUL;
			end
			OP_INDIRECT_JUMP: begin
				npc = PC_W'(req_in.z_ptr); // RL9
				cyc = `CYC_INDIRECT_JUMP;
			end
			OP_INDIRECT_CALL: begin
				npc = PC_W'(req_in.z_ptr); // RL10
				cyc = `CYC_CALL;
			end
			OP_RELATIVE_CALL: begin
				npc = cur_pc + PC_W'(`PC_STEP) + PC_W'($signed(req_in.offset)); // RL10
				cyc = `CYC_CALL;
			end
			OP_COMPARE_SKIP_EQUAL: begin
				is_skip = 1'b1;
				cond = (d == r); // RL11
			end
			OP_SKIP_REG_BIT_CLEAR, OP_SKIP_REG_BIT_SET: begin
				is_skip = 1'b1;
				cond = r[req_in.bit_sel] == (req_in.op == OP_SKIP_REG_BIT_SET); // RL13
			end
			OP_SKIP_IO_BIT_CLEAR, OP_SKIP_IO_BIT_SET: begin
				is_skip = 1'b1;
				cond = req_in.io_val[req_in.bit_sel] == (req_in.op == OP_SKIP_IO_BIT_SET); // RL14
			end
			default: begin
				is_br = 1'b1;
				case (req_in.op)
					OP_BRANCH_STATUS_BIT_SET: cond = cur_status_register[req_in.bit_sel]; // RL15
					OP_BRANCH_STATUS_BIT_CLEAR: cond = ~cur_status_register[req_in.bit_sel]; // RL15
					OP_BRANCH_SIGNED_GE: cond = ~(cur_status_register[`SR_N] ^ cur_status_register[`SR_V]); // RL16
					OP_BRANCH_SIGNED_LT: cond = cur_status_register[`SR_N] ^ cur_status_register[`SR_V]; // RL16
					OP_BRANCH_UNSIGNED_GE: cond = ~cur_status_register[`SR_C]; // RL17
					OP_BRANCH_UNSIGNED_LT: cond = cur_status_register[`SR_C]; // RL17
					OP_BRANCH_CARRY_ONE: cond = cur_status_register[`SR_C]; // RL18
					OP_BRANCH_CARRY_ZERO: cond = ~cur_status_register[`SR_C]; // RL18
					OP_BRANCH_HALFCARRY_ONE: cond = cur_status_register[`SR_H]; // RL19
					OP_BRANCH_HALFCARRY_ZERO: cond = ~cur_status_register[`SR_H]; // RL19
					OP_BRANCH_OVERFLOW_ONE: cond = cur_status_register[`SR_V]; // RL20
					OP_BRANCH_TRANSFER_ONE: cond = cur_status_register[`SR_T]; // RL21
					OP_BRANCH_TRANSFER_ZERO: cond = ~cur_status_register[`SR_T]; // RL21
					default: cond = 1'b0;
				endcase
			end
		endcase
		if (is_skip && cond) begin
			npc = cur_pc + PC_W'(req_in.next_two_word ? `SKIP_TWO : `SKIP_ONE); // RL22
			cyc = req_in.next_two_word ? `CYC_SKIP_TWO : `CYC_SKIP_ONE; // RL22
		end
		if (is_br && cond) begin
			npc = cur_pc + PC_W'(`PC_STEP) + PC_W'($signed(req_in.offset)); // RL15
			cyc = `CYC_BR_TAKEN; // RL22
		end
		if (!wr_pair && !wr_mul) begin
			wres = {8'h00, res};
		end
	end

	always_comb begin
		nxt_state = state_ff;
		nxt_cnt = cnt_ff;
		nxt_done = 1'b0;
		nxt_status_register = status_register_ff;
		nxt_pc = pc_ff;
		nxt_wr = '0;
		nxt_push = '0;
		nxt_pend_status_register = pend_status_register_ff;
		nxt_pend_pc = pend_pc_ff;
		nxt_pend_wr = pend_wr_ff;
		nxt_pend_push = pend_push_ff;
		if (state_ff == ST_EXEC) begin
			if (cnt_ff != 2'd0) begin
				nxt_cnt = cnt_ff - 2'd1;
			end else begin
				nxt_status_register = pend_status_register_ff;
				nxt_pc = pend_pc_ff;
				nxt_wr = pend_wr_ff;
				nxt_push = pend_push_ff;
				nxt_done = 1'b1;
				nxt_state = ST_IDLE;
			end
		end
		if (take) begin
			nxt_state = ST_EXEC;
			nxt_cnt = cyc - 2'd1;
			nxt_pend_status_register = fl;
			nxt_pend_pc = npc;
			nxt_pend_wr = '{en: wr_en, pair: wr_pair, to_r1r0: wr_mul, data: wres};
			nxt_pend_push.en = (req_in.op == OP_INDIRECT_CALL) || (req_in.op == OP_RELATIVE_CALL);
			nxt_pend_push.addr = 16'(cur_pc + PC_W'(`PC_STEP));
		end
		nxt_ready = (nxt_cnt == 2'd0);
	end

	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			state_ff <= ST_IDLE;
			cnt_ff <= 2'd0;
			ready_ff <= 1'b1;
			done_ff <= 1'b0;
			status_register_ff <= `STATUS_REGISTER_RST;
			pc_ff <= PC_W'(`PC_RST);
			wr_ff <= '0;
			push_ff <= '0;
			pend_status_register_ff <= `STATUS_REGISTER_RST;
			pend_pc_ff <= PC_W'(`PC_RST);
			pend_wr_ff <= '0;
			pend_push_ff <= '0;
		end else begin
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
			ready_ff <= nxt_ready;
			done_ff <= nxt_done;
			status_register_ff <= nxt_status_register;
			pc_ff <= nxt_pc;
			wr_ff <= nxt_wr;
			push_ff <= nxt_push;
			pend_status_register_ff <= nxt_pend_status_register;
			pend_pc_ff <= nxt_pend_pc;
			pend_wr_ff <= nxt_pend_wr;
			pend_push_ff <= nxt_pend_push;
		end
	end

	assign ready_out = ready_ff;
	assign done_out = done_ff;
	assign wr_out = wr_ff;
	assign push_out = push_ff;
	assign status_out = status_register_ff;
	assign pc_out = pc_ff;
endmodule : cpu_alu_branch_exec
`default_nettype wire

// >>> pkg/cpu_alu_defines.svh
`ifndef CPU_ALU_DEFINES_SVH
`define CPU_ALU_DEFINES_SVH
// Status register bit positions.
`define SR_C 3'd0
`define SR_Z 3'd1
`define SR_N 3'd2
`define SR_V 3'd3
`define SR_S 3'd4
`define SR_H 3'd5
`define SR_T 3'd6
`define SR_I 3'd7
// Reset values.
`define STATUS_REGISTER_RST 8'h00
`define PC_RST 16'h0000
// Cycle counts per instruction class.
`define CYC_ALU 2'd1
`define CYC_WORD 2'd2
`define CYC_MUL 2'd2
`define CYC_INDIRECT_JUMP 2'd2
`define CYC_CALL 2'd3
`define CYC_BR_TAKEN 2'd2
`define CYC_SKIP_ONE 2'd2
`define CYC_SKIP_TWO 2'd3
// Program counter advance for skips and branches.
`define SKIP_ONE 16'h0002
`define SKIP_TWO 16'h0003
`define PC_STEP 16'h0001
// Complement base for clear-bits.
`define MASK_ALL 8'hff
`endif

// >>> pkg/cpu_alu_pkg.sv
package cpu_alu_pkg;
	typedef enum logic [5:0] {
		OP_ADD, OP_ADD_CARRY, OP_SUB, OP_SUB_BORROW, OP_SUBTRACT_CONSTANT,
		OP_SUBTRACT_CONSTANT_WITH_BORROW, OP_AND, OP_AND_CONSTANT, OP_OR, OP_OR_CONSTANT,
		OP_EXCLUSIVE_OR, OP_SET_BITS_MASK, OP_CLEAR_BITS_MASK, OP_ZERO_MINUS_TEST,
		OP_WORD_ADD_IMMEDIATE, OP_WORD_SUBTRACT_IMMEDIATE, OP_MULTIPLY, OP_SIGNED_MULTIPLY,
		OP_SIGNED_UNSIGNED_MULTIPLY, OP_FRACTIONAL_MULTIPLY, OP_FRACTIONAL_SIGNED_MULTIPLY,
		OP_FRACTIONAL_MIXED_MULTIPLY, OP_INDIRECT_JUMP, OP_INDIRECT_CALL, OP_RELATIVE_CALL,
		OP_COMPARE_SKIP_EQUAL, OP_COMPARE, OP_COMPARE_WITH_CARRY, OP_COMPARE_IMMEDIATE,
		OP_SKIP_REG_BIT_CLEAR, OP_SKIP_REG_BIT_SET, OP_SKIP_IO_BIT_CLEAR, OP_SKIP_IO_BIT_SET,
		OP_BRANCH_STATUS_BIT_SET, OP_BRANCH_STATUS_BIT_CLEAR, OP_BRANCH_SIGNED_GE,
		OP_BRANCH_SIGNED_LT, OP_BRANCH_UNSIGNED_GE, OP_BRANCH_UNSIGNED_LT, OP_BRANCH_CARRY_ONE,
		OP_BRANCH_CARRY_ZERO, OP_BRANCH_HALFCARRY_ONE, OP_BRANCH_HALFCARRY_ZERO,
		OP_BRANCH_OVERFLOW_ONE, OP_BRANCH_TRANSFER_ONE, OP_BRANCH_TRANSFER_ZERO
	} exec_op_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_EXEC = 2'b10
	} exec_state_t;

	typedef struct packed {
		exec_op_t op;
		logic [7:0] rd_val;
		logic [7:0] rd_hi_val;
		logic [7:0] rr_val;
		logic [7:0] io_val;
		logic [2:0] bit_sel;
		logic [11:0] offset;
		logic [15:0] z_ptr;
		logic next_two_word;
	} exec_req_t;

	typedef struct packed {
		logic en;
		logic pair;
		logic to_r1r0;
		logic [15:0] data;
	} reg_write_t;

	typedef struct packed {
		logic en;
		logic [15:0] addr;
	} ret_push_t;
endpackage : cpu_alu_pkg

// >>> verif/cpu_alu_exec_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module cpu_alu_exec_asserts #(
	parameter int PC_W = 16
) (
	input wire logic sys_clk_in,
	input wire logic rstn_in,
	input wire logic req_valid_in,
	input wire cpu_alu_pkg::exec_req_t req_in,
	input wire logic ready_out,
	input wire logic done_out,
	input wire cpu_alu_pkg::reg_write_t wr_out,
	input wire cpu_alu_pkg::ret_push_t push_out,
	input wire logic [7:0] status_out,
	input wire logic [PC_W-1:0] pc_out
);
	import cpu_alu_pkg::*;
	logic take;
	logic [15:0] sx;
	assign take = ready_out && req_valid_in;
	assign sx = {{4{req_in.offset[11]}}, req_in.offset};
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!rstn_in);
	add_one_cycle_a: assert property (take && req_in.op == OP_ADD |-> ##2 done_out && wr_out.en)
		else $error("add did not commit after one cycle");
	word_two_cycle_a: assert property (take && req_in.op inside {OP_WORD_ADD_IMMEDIATE,
		OP_WORD_SUBTRACT_IMMEDIATE} |-> ##2 !done_out ##1 done_out && wr_out.pair)
		else $error("word op timing or pair write wrong");
	logic_flags_a: assert property (take && req_in.op inside {OP_AND, OP_AND_CONSTANT, OP_OR,
		OP_OR_CONSTANT, OP_EXCLUSIVE_OR, OP_SET_BITS_MASK, OP_CLEAR_BITS_MASK, OP_ZERO_MINUS_TEST} |-> ##2 !status_out[3]
		&& status_out[0] == $past(status_out[0]) && status_out[7:4] == $past(status_out[7:4]))
		else $error("logic op touched a flag it must keep");
	mul_two_cycle_a: assert property (take && req_in.op inside {[OP_MULTIPLY:OP_FRACTIONAL_MIXED_MULTIPLY]}
		|-> ##2 !done_out ##1 done_out && wr_out.to_r1r0) else $error("multiply timing or target wrong");
	jump_target_a: assert property (take && req_in.op == OP_INDIRECT_JUMP |-> ##3 done_out
		&& pc_out == $past(req_in.z_ptr, 3) && status_out == $past(status_out, 2))
		else $error("indirect jump target or flags wrong");
	call_push_a: assert property (take && req_in.op inside {OP_INDIRECT_CALL, OP_RELATIVE_CALL}
		|-> ##2 !done_out [*2] ##1 done_out && push_out.en) else $error("call did not commit after three cycles");
	skip_two_a: assert property (take && req_in.op == OP_COMPARE_SKIP_EQUAL
		&& req_in.rd_val == req_in.rr_val && req_in.next_two_word
		|-> ##4 done_out && pc_out == $past(pc_out, 3) + 16'h0003) else $error("skip over two words wrong");
	branch_taken_a: assert property (take && req_in.op == OP_BRANCH_TRANSFER_ZERO && !status_out[6]
		|-> ##1 !ready_out ##2 done_out && pc_out == $past(pc_out, 2) + 16'h0001 + $past(sx, 3))
		else $error("taken branch target or timing wrong");
	branch_untaken_a: assert property (take && req_in.op == OP_BRANCH_TRANSFER_ONE && !status_out[6]
		|-> ##2 done_out && pc_out == $past(pc_out) + 16'h0001) else $error("untaken branch wrong");
	cover property (take && req_in.op == OP_MULTIPLY);
	cover property (done_out && push_out.en);
	cover property (take && req_in.op == OP_COMPARE_SKIP_EQUAL && req_in.next_two_word);
endmodule : cpu_alu_exec_asserts
bind cpu_alu_branch_exec cpu_alu_exec_asserts #(.PC_W(PC_W)) u_cpu_alu_exec_asserts (.sys_clk_in, .rstn_in,
	.req_valid_in, .req_in, .ready_out, .done_out, .wr_out, .push_out, .status_out, .pc_out);
`default_nettype wire

// >>> verif/reg_file_model.sv
`timescale 1ns/1ps
`default_nettype none
module reg_file_model (
	input wire logic sys_clk_in,
	input wire cpu_alu_pkg::reg_write_t wr_in,
	input wire logic [4:0] idx_in,
	input wire logic ld_in,
	input wire logic [7:0] ld_val_in,
	output logic [15:0] q_out,
	output logic [15:0] r10_out
);
	logic [7:0] regs_ff [32];
	always_ff @(posedge sys_clk_in) begin
		if (ld_in) begin
			regs_ff[idx_in] <= ld_val_in;
		end else if (wr_in.en && wr_in.to_r1r0) begin
			regs_ff[0] <= wr_in.data[7:0];
			regs_ff[1] <= wr_in.data[15:8];
		end else if (wr_in.en) begin
			regs_ff[idx_in] <= wr_in.data[7:0];
			if (wr_in.pair) begin
				regs_ff[idx_in + 5'h01] <= wr_in.data[15:8];
			end
		end
	end
	assign q_out = {regs_ff[idx_in + 5'h01], regs_ff[idx_in]};
	assign r10_out = {regs_ff[1], regs_ff[0]};
endmodule : reg_file_model
`default_nettype wire

// >>> verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import cpu_alu_pkg::*;
	logic sys_clk_in = 1'b0;
	logic rstn_in = 1'b0;
	logic req_valid_in = 1'b0;
	exec_req_t req_in = '0;
	logic ready_out, done_out, ld = 1'b0;
	reg_write_t wr_out;
	ret_push_t push_out;
	logic [7:0] status_out, ld_val = 8'h00;
	logic [15:0] pc_out, q_val, r10_val;
	logic [4:0] idx = 5'h02;
	int err_total = 0;
	int check_count = 0;
	always #20 sys_clk_in = ~sys_clk_in;
	cpu_alu_branch_exec u_cpu_alu_branch_exec (.sys_clk_in, .rstn_in, .req_valid_in, .req_in, .ready_out,
		.done_out, .wr_out, .push_out, .status_out, .pc_out);
	reg_file_model u_reg_file_model (.sys_clk_in, .wr_in(wr_out), .idx_in(idx), .ld_in(ld), .ld_val_in(ld_val),
		.q_out(q_val), .r10_out(r10_val));
	task automatic stop_test();
		$display("checks=%0d errors=%0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : stop_test
	task automatic chk_val(logic [15:0] g, logic [15:0] e);
		check_count++;
		if (g !== e) begin
			err_total++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk_val
	task automatic chk_flags(logic [7:0] g, logic [7:0] e);
		check_count++;
		if (g !== e) begin
			err_total++;
			$display("[ERR] t=%0t flags got=%h exp=%h", $time, g, e);
		end
	endtask : chk_flags
	function automatic logic [23:0] expect_f(exec_op_t op, logic [7:0] a, logic [7:0] b, logic [7:0] sr);
		logic [8:0] w;
		logic [4:0] h;
		logic [15:0] p;
		logic [7:0] s;
		logic c;
		int k;
		s = sr;
		c = sr[0] && op inside {OP_ADD_CARRY, OP_SUB_BORROW, OP_SUBTRACT_CONSTANT_WITH_BORROW, OP_COMPARE_WITH_CARRY};
		k = 2;
		w = {1'b0, a & b};
		h = 5'h00;
		p = a * b;
		case (op)
			OP_ADD, OP_ADD_CARRY: begin
				w = a + b + c;
				h = a[3:0] + b[3:0] + c;
				s[3] = (a[7] == b[7]) && (w[7] != a[7]);
				k = 1;
			end
			OP_SUB, OP_SUB_BORROW, OP_SUBTRACT_CONSTANT, OP_SUBTRACT_CONSTANT_WITH_BORROW, OP_COMPARE,
			OP_COMPARE_WITH_CARRY, OP_COMPARE_IMMEDIATE: begin
				w = a - b - c;
				h = a[3:0] - b[3:0] - c;
				s[3] = (a[7] != b[7]) && (w[7] != a[7]);
				k = 1;
			end
			OP_OR, OP_OR_CONSTANT, OP_SET_BITS_MASK: w = {1'b0, a | b};
			OP_EXCLUSIVE_OR: w = {1'b0, a ^ b};
			OP_CLEAR_BITS_MASK: w = {1'b0, a & (8'hff - b)};
			OP_AND, OP_AND_CONSTANT, OP_ZERO_MINUS_TEST: k = 2;
			OP_MULTIPLY, OP_FRACTIONAL_MULTIPLY: k = 3;
			OP_SIGNED_MULTIPLY, OP_FRACTIONAL_SIGNED_MULTIPLY: begin
				p = 16'($signed(a) * $signed(b));
				k = 3;
			end
			OP_SIGNED_UNSIGNED_MULTIPLY, OP_FRACTIONAL_MIXED_MULTIPLY: begin
				p = 16'($signed(a) * $signed({1'b0, b}));
				k = 3;
			end
			default: k = 0;
		endcase
		if (k == 1) begin
			s[0] = w[8];
			s[5] = h[4];
		end
		if (k == 2) s[3] = 1'b0;
		if (k == 1 || k == 2) begin
			s[2] = w[7];
			s[1] = (w[7:0] == 8'h00) && (sr[1] || !(op inside {OP_SUB_BORROW, OP_SUBTRACT_CONSTANT_WITH_BORROW,
				OP_COMPARE_WITH_CARRY}));
		end
		if (k == 3) begin
			s[0] = p[15];
			if (op inside {OP_FRACTIONAL_MULTIPLY, OP_FRACTIONAL_SIGNED_MULTIPLY, OP_FRACTIONAL_MIXED_MULTIPLY}) p = p << 1;
			s[1] = p == 16'h0000;
		end else p = {8'h00, w[7:0]};
		return {s, p};
	endfunction : expect_f
	function automatic logic [19:0] pc_f(exec_req_t r, logic [7:0] sr, logic [15:0] pc);
		logic t;
		logic [3:0] n;
		logic [15:0] nx;
		logic [15:0] sx;
		t = 1'b0;
		n = 4'h1;
		nx = pc + 16'h0001;
		sx = {{4{r.offset[11]}}, r.offset};
		case (r.op)
			OP_COMPARE_SKIP_EQUAL: t = r.rd_val == r.rr_val;
			OP_SKIP_REG_BIT_CLEAR: t = !r.rd_val[r.bit_sel];
			OP_SKIP_REG_BIT_SET: t = r.rd_val[r.bit_sel];
			OP_SKIP_IO_BIT_CLEAR: t = !r.io_val[r.bit_sel];
			OP_SKIP_IO_BIT_SET: t = r.io_val[r.bit_sel];
			OP_BRANCH_STATUS_BIT_SET: t = sr[r.bit_sel];
			OP_BRANCH_STATUS_BIT_CLEAR: t = !sr[r.bit_sel];
			OP_BRANCH_SIGNED_GE: t = !(sr[2] ^ sr[3]);
			OP_BRANCH_SIGNED_LT: t = sr[2] ^ sr[3];
			OP_BRANCH_UNSIGNED_GE, OP_BRANCH_CARRY_ZERO: t = !sr[0];
			OP_BRANCH_UNSIGNED_LT, OP_BRANCH_CARRY_ONE: t = sr[0];
			OP_BRANCH_HALFCARRY_ONE: t = sr[5];
			OP_BRANCH_HALFCARRY_ZERO: t = !sr[5];
			OP_BRANCH_OVERFLOW_ONE: t = sr[3];
			OP_BRANCH_TRANSFER_ONE: t = sr[6];
			OP_BRANCH_TRANSFER_ZERO: t = !sr[6];
			OP_INDIRECT_JUMP: {n, nx} = {4'h2, r.z_ptr};
			OP_INDIRECT_CALL: {n, nx} = {4'h3, r.z_ptr};
			OP_RELATIVE_CALL: {n, nx} = {4'h3, nx + sx};
			OP_COMPARE, OP_COMPARE_WITH_CARRY, OP_COMPARE_IMMEDIATE: t = 1'b0;
			default: if (r.op >= OP_WORD_ADD_IMMEDIATE) n = 4'h2;
		endcase
		if (t && r.op < OP_BRANCH_STATUS_BIT_SET) {n, nx} = {4'h2 + r.next_two_word, nx + 16'h0001 + r.next_two_word};
		if (t && r.op >= OP_BRANCH_STATUS_BIT_SET) {n, nx} = {4'h2, nx + sx};
		return {n, nx};
	endfunction : pc_f
	task automatic run(exec_op_t op, logic [7:0] a, logic [7:0] b, logic two);
		logic [23:0] ex;
		logic [19:0] pe;
		logic [15:0] pc;
		logic skip_d;
		logic [16:0] wv;
		logic vw;
		int n;
		@(posedge sys_clk_in);
		#1;
		ld = 1'b1;
		ld_val = a;
		idx = 5'($urandom_range(2, 29));
		@(posedge sys_clk_in);
		#1;
		ld = 1'b0;
		if (op inside {OP_SKIP_REG_BIT_CLEAR, OP_SKIP_REG_BIT_SET, OP_ZERO_MINUS_TEST}) b = a;
		if (op inside {OP_WORD_ADD_IMMEDIATE, OP_WORD_SUBTRACT_IMMEDIATE}) b = b & 8'h3f;
		req_in = '{op, a, 8'($urandom), b, 8'($urandom), 3'($urandom), 12'($urandom), 16'($urandom), two};
		req_valid_in = 1'b1;
		pc = pc_out;
		ex = expect_f(op, a, b, status_out);
		pe = pc_f(req_in, status_out, pc);
		skip_d = op inside {OP_WORD_ADD_IMMEDIATE, OP_WORD_SUBTRACT_IMMEDIATE};
		@(posedge sys_clk_in);
		#1;
		req_valid_in = 1'b0;
		n = 0;
		while (done_out !== 1'b1) begin
			if (n == 8) begin
				err_total++;
				stop_test();
			end
			@(posedge sys_clk_in);
			#1;
			n++;
		end
		chk_val(16'(n), {12'h000, pe[19:16]});
		chk_val(pc_out, pe[15:0]);
		chk_val({15'h0000, push_out.en}, {15'h0000, op inside {OP_INDIRECT_CALL, OP_RELATIVE_CALL}});
		if (push_out.en === 1'b1) chk_val(push_out.addr, pc + 16'h0001);
		if (!skip_d) chk_flags(status_out, ex[23:16]);
		if (skip_d) begin
			wv = op == OP_WORD_ADD_IMMEDIATE ? {1'b0, req_in.rd_hi_val, a} + 17'(b) : {1'b0, req_in.rd_hi_val, a} - 17'(b);
			vw = op == OP_WORD_ADD_IMMEDIATE ? !req_in.rd_hi_val[7] && wv[15] : req_in.rd_hi_val[7] && !wv[15];
			chk_val(wr_out.data, wv[15:0]);
			chk_flags(status_out, {ex[23:21], wv[15] ^ vw, vw, wv[15], wv[15:0] == 16'h0000, wv[16]});
		end
		@(posedge sys_clk_in);
		#1;
		if (op inside {[OP_MULTIPLY:OP_FRACTIONAL_MIXED_MULTIPLY]}) chk_val(r10_val, ex[15:0]);
		else if (!skip_d) chk_val({8'h00, q_val[7:0]}, {8'h00, op < OP_WORD_ADD_IMMEDIATE ? ex[7:0] : a});
	endtask : run
	initial begin
		void'($urandom(32'hfc0aff7e));
		repeat (5) @(posedge sys_clk_in);
		#1;
		rstn_in = 1'b1;
		run(OP_ADD, 8'hff, 8'h01, 1'b0);
		run(OP_SUB, 8'h00, 8'h01, 1'b0);
		run(OP_COMPARE_SKIP_EQUAL, 8'h5a, 8'h5a, 1'b1);
		run(OP_COMPARE_SKIP_EQUAL, 8'h5a, 8'h5a, 1'b0);
		run(OP_MULTIPLY, 8'hff, 8'hff, 1'b0);
		run(OP_CLEAR_BITS_MASK, 8'hff, 8'h0f, 1'b0);
		repeat (400) run(exec_op_t'($urandom_range(0, 45)), 8'($urandom), 8'($urandom), 1'($urandom));
		stop_test();
	end
endmodule : testbench
`default_nettype wire
